// file: verilog/dslab_pkg.sv
// package: register map, field layout and constants of the drop-side alarm bank
package dslab_pkg;
   // printed offsets are not all multiples of four: they are indices, byte = 4*index
   localparam logic [11:0] DSLAB_IDX_PTR_FIFO = 12'h115;
   localparam logic [11:0] DSLAB_IDX_TRACE = 12'h116;
   localparam logic [11:0] DSLAB_IDX_TANDEM = 12'h117;
   localparam logic [11:0] DSLAB_IDX_POLARITY = 12'h120;
   localparam logic [11:0] DSLAB_IDX_IRQ_STAT = 12'h121;
   localparam logic [11:0] DSLAB_IDX_IRQ_EN = 12'h122;
   localparam logic [11:0] DSLAB_IDX_IRQ_CLR = 12'h123;
   localparam logic [11:0] DSLAB_IDX_TC_FRAME = 12'h124;
   localparam int DSLAB_ADDR_W = 14;
   localparam int DSLAB_REG_W = 8;
   localparam int DSLAB_NSRC = 14;
   // source vector layout
   localparam int DSLAB_SRC_FIFO = 0;
   localparam int DSLAB_SRC_AIS = 1;
   localparam int DSLAB_SRC_LOP = 2;
   localparam int DSLAB_SRC_NDF = 3;
   localparam int DSLAB_SRC_SIZE = 4;
   localparam int DSLAB_SRC_J2TIM = 5;
   localparam int DSLAB_SRC_J2LOL = 6;
   localparam int DSLAB_SRC_TCLM = 7;
   localparam int DSLAB_SRC_TCLL = 8;
   localparam int DSLAB_SRC_TCTM = 9;
   localparam int DSLAB_SRC_TCAIS = 10;
   localparam int DSLAB_SRC_TCUQ = 11;
   localparam int DSLAB_SRC_TCRDI = 12;
   localparam int DSLAB_SRC_TCODI = 13;
   // bit positions within the registers
   localparam int DSLAB_BIT_FIFO = 4;
   localparam int DSLAB_BIT_AIS = 3;
   localparam int DSLAB_BIT_LOP = 2;
   localparam int DSLAB_BIT_NDF = 1;
   localparam int DSLAB_BIT_SIZE = 0;
   localparam int DSLAB_BIT_J2TIM = 1;
   localparam int DSLAB_BIT_J2LOL = 0;
   localparam int DSLAB_BIT_TCLM = 7;
   localparam int DSLAB_BIT_TCLL = 6;
   localparam int DSLAB_BIT_TCTM = 5;
   localparam int DSLAB_BIT_TCAIS = 4;
   localparam int DSLAB_BIT_TCUQ = 3;
   localparam int DSLAB_BIT_TCRDI = 2;
   localparam int DSLAB_BIT_TCODI = 1;
   // n2 byte bit 4 (bits numbered 1..8 from msb) is vector bit 4
   localparam int DSLAB_N2_AIS_BIT = 4;
   localparam logic [2:0] DSLAB_TC_PERSIST = 3'h5;
   // polarity select codes
   typedef enum logic [1:0] {
      DSLAB_POL_RISE = 2'b00,
      DSLAB_POL_FALL = 2'b01,
      DSLAB_POL_BOTH = 2'b10
   } dslab_pol_t;
   localparam logic [1:0] DSLAB_POL_RESET = 2'h2;
   localparam logic [2:0] DSLAB_IRQ_W = 3'h3;
endpackage : dslab_pkg

// file: verilog/dslab_tc_ais.sv
// tandem-connection ais persistence detector on the n2 byte
`timescale 1ns/100ps
`default_nettype none
module dslab_tc_ais (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic frame_valid,
   input wire logic [7:0] n2_byte,
   output logic tc_alarm_signal
);
   import dslab_pkg::*;
   typedef struct packed {
      logic [2:0] run;
      logic alarm;
   } dslab_tc_st_t;
   dslab_tc_st_t s_q, s_d;
   logic want;
   always_comb begin
      s_d = s_q;
      // bit 4 counted msb-first is bit index 8-4 of the byte
      want = n2_byte[8 - DSLAB_N2_AIS_BIT];
      if (frame_valid) begin
         if (want == s_q.alarm) begin
            s_d.run = '0;
         end else if (s_q.run + 3'h1 >= DSLAB_TC_PERSIST) begin
            s_d.alarm = want;
            s_d.run = '0;
         end else begin
            s_d.run = s_q.run + 3'h1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tc_alarm_signal = s_q.alarm;
endmodule // dslab_tc_ais
`default_nettype wire

// file: verilog/dslab_bank.sv
// latched alarm bank for one a-side drop channel with apb register access
// Summary of operation
// - a bit sets on a source transition of the selected polarity
// - reading a latched register returns the bits and then clears them
// - first register bit 4 latches desynchronizer fifo error
// - first register bit 3 latches tributary alarm indication signal
// - first register bit 2 latches loss of pointer
// - first register bit 1 latches new data flag
// - first register bit 0 latches incorrect pointer size
// - second register bit 1 latches path trace mismatch
// - second register bit 0 latches path trace loss of lock
// - third register bit 7 latches tc loss of multiframe
// - third register bit 6 latches tc trace loss of lock
// - third register bit 5 latches tc trace mismatch
// - third register bit 4 latches tc alarm indication signal
// - third register bit 3 latches tc unequipped
// - third register bit 2 latches tc remote defect indication
// - third register bit 1 latches tc outgoing defect indication
// - tc ais asserts or clears after five equal n2 bit 4 frames
`timescale 1ns/100ps
`default_nettype none
module dslab_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dslab_pkg::DSLAB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [dslab_pkg::DSLAB_NSRC-1:0] alarm_src,
   input wire logic n2_frame_valid,
   input wire logic [7:0] n2_byte,
   output logic irq
);
   import dslab_pkg::*;

   typedef struct packed {
      logic [DSLAB_NSRC-1:0] sync1;
      logic [DSLAB_NSRC-1:0] sync2;
      logic [DSLAB_NSRC-1:0] prev;
      logic prev_valid;
      logic [DSLAB_REG_W-1:0] lat_ptr;
      logic [DSLAB_REG_W-1:0] lat_trace;
      logic [DSLAB_REG_W-1:0] lat_tc;
      logic [1:0] pol;
      logic [DSLAB_IRQ_W-1:0] irq_stat;
      logic [DSLAB_IRQ_W-1:0] irq_en;
      logic tc_frame_seen;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic irq;
   } dslab_st_t;

   dslab_st_t s_q, s_d;
   logic tc_ais;
   logic [DSLAB_NSRC-1:0] live;
   logic [DSLAB_NSRC-1:0] rise;
   logic [DSLAB_NSRC-1:0] fall;
   logic [DSLAB_NSRC-1:0] hit;
   logic [DSLAB_REG_W-1:0] ev_ptr;
   logic [DSLAB_REG_W-1:0] ev_trace;
   logic [DSLAB_REG_W-1:0] ev_tc;
   logic [DSLAB_IRQ_W-1:0] ev_irq;
   logic setup;
   logic rd;
   logic wr;
   logic [11:0] idx;
   logic aligned;

   dslab_tc_ais u_tc_ais (
      .pclk(pclk),
      .presetn(presetn),
      .frame_valid(n2_frame_valid),
      .n2_byte(n2_byte),
      .tc_alarm_signal(tc_ais)
   );

   // per-source edge detection on the synchronised level
   genvar g;
   generate
      for (g = 0; g < DSLAB_NSRC; g++) begin : g_edge
         assign rise[g] = live[g] & ~s_q.prev[g];
         assign fall[g] = ~live[g] & s_q.prev[g];
         assign hit[g] = s_q.prev_valid &
            (((s_q.pol == DSLAB_POL_RISE) & rise[g]) |
             ((s_q.pol == DSLAB_POL_FALL) & fall[g]) |
             ((s_q.pol == DSLAB_POL_BOTH) & (rise[g] | fall[g])));
      end
   endgenerate

   always_comb begin
      live = s_q.sync2;
      // on-chip persistence detector drives the tc ais source
      live[DSLAB_SRC_TCAIS] = tc_ais;
      ev_ptr = '0;
      ev_trace = '0;
      ev_tc = '0;
      ev_ptr[DSLAB_BIT_FIFO] = hit[DSLAB_SRC_FIFO];
      ev_ptr[DSLAB_BIT_AIS] = hit[DSLAB_SRC_AIS];
      ev_ptr[DSLAB_BIT_LOP] = hit[DSLAB_SRC_LOP];
      ev_ptr[DSLAB_BIT_NDF] = hit[DSLAB_SRC_NDF];
      ev_ptr[DSLAB_BIT_SIZE] = hit[DSLAB_SRC_SIZE];
      ev_trace[DSLAB_BIT_J2TIM] = hit[DSLAB_SRC_J2TIM];
      ev_trace[DSLAB_BIT_J2LOL] = hit[DSLAB_SRC_J2LOL];
      ev_tc[DSLAB_BIT_TCLM] = hit[DSLAB_SRC_TCLM];
      ev_tc[DSLAB_BIT_TCLL] = hit[DSLAB_SRC_TCLL];
      ev_tc[DSLAB_BIT_TCTM] = hit[DSLAB_SRC_TCTM];
      ev_tc[DSLAB_BIT_TCAIS] = hit[DSLAB_SRC_TCAIS];
      ev_tc[DSLAB_BIT_TCUQ] = hit[DSLAB_SRC_TCUQ];
      ev_tc[DSLAB_BIT_TCRDI] = hit[DSLAB_SRC_TCRDI];
      ev_tc[DSLAB_BIT_TCODI] = hit[DSLAB_SRC_TCODI];
      ev_irq = {|ev_tc, |ev_trace, |ev_ptr};
   end

   always_comb begin
      s_d = s_q;
      setup = psel & ~penable;
      rd = setup & ~pwrite;
      wr = setup & pwrite;
      idx = paddr[DSLAB_ADDR_W-1:2];
      aligned = (paddr[1:0] == 2'b00);
      s_d.sync1 = alarm_src;
      s_d.sync2 = s_q.sync1;
      s_d.prev = live;
      s_d.prev_valid = 1'b1;
      s_d.ready = setup;
      s_d.slverr = 1'b0;
      if (n2_frame_valid) begin
         s_d.tc_frame_seen = 1'b1;
      end
      // answer computed in setup, presented with pready in the access cycle
      if (setup) begin
         s_d.rdata = '0;
         if (!aligned) begin
            s_d.slverr = 1'b1;
         end else begin
            unique case (idx)
               DSLAB_IDX_PTR_FIFO: begin
                  if (rd) begin
                     s_d.rdata[DSLAB_REG_W-1:0] = s_q.lat_ptr;
                     s_d.lat_ptr = '0;
                  end
               end
               DSLAB_IDX_TRACE: begin
                  if (rd) begin
                     s_d.rdata[DSLAB_REG_W-1:0] = s_q.lat_trace;
                     s_d.lat_trace = '0;
                  end
               end
               DSLAB_IDX_TANDEM: begin
                  if (rd) begin
                     s_d.rdata[DSLAB_REG_W-1:0] = s_q.lat_tc;
                     s_d.lat_tc = '0;
                  end
               end
               DSLAB_IDX_POLARITY: begin
                  if (wr && pwdata[1:0] != 2'b11) begin
                     s_d.pol = pwdata[1:0];
                  end
                  s_d.rdata[1:0] = s_q.pol;
               end
               DSLAB_IDX_IRQ_STAT: begin
                  s_d.rdata[DSLAB_IRQ_W-1:0] = s_q.irq_stat;
               end
               DSLAB_IDX_IRQ_EN: begin
                  if (wr) begin
                     s_d.irq_en = pwdata[DSLAB_IRQ_W-1:0];
                  end
                  s_d.rdata[DSLAB_IRQ_W-1:0] = s_q.irq_en;
               end
               DSLAB_IDX_IRQ_CLR: begin
                  if (wr) begin
                     s_d.irq_stat = s_q.irq_stat &
                        ~pwdata[DSLAB_IRQ_W-1:0];
                  end
               end
               DSLAB_IDX_TC_FRAME: begin
                  s_d.rdata[0] = s_q.tc_frame_seen;
                  if (rd) begin
                     s_d.tc_frame_seen = n2_frame_valid;
                  end
               end
               default: begin
                  s_d.slverr = 1'b1;
               end
            endcase
         end
      end
      // new events override any clear in the same cycle; unused bits stay 0
      s_d.lat_ptr = s_d.lat_ptr | ev_ptr;
      s_d.lat_trace = s_d.lat_trace | ev_trace;
      s_d.lat_tc = s_d.lat_tc | ev_tc;
      s_d.irq_stat = s_d.irq_stat | ev_irq;
      s_d.irq = |(s_d.irq_stat & s_d.irq_en);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.pol <= DSLAB_POL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.slverr;
   assign irq = s_q.irq;
endmodule // dslab_bank
`default_nettype wire

// file: verification/dslab_bank_monitor.sv
// checker for bus timing and unused bits of the drop-side alarm bank
`timescale 1ns/100ps
`default_nettype none
module dslab_bank_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dslab_pkg::DSLAB_ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import dslab_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic st = psel && !penable;
   wire logic rd = st && !pwrite;
   property p_rdy; st |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no pready after setup");
   property p_only; !st |=> !pready; endproperty
   a_only: assert property (p_only) else $error("pready without setup");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("pslverr without pready");
   property p_unmap; st && paddr[13:2] > DSLAB_IDX_TC_FRAME |=> pslverr;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped not refused");
   property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("prdata upper bits set");
   property p_ptr; rd && paddr[13:2] == DSLAB_IDX_PTR_FIFO
      |=> prdata[7:5] == 3'h0; endproperty
   a_ptr: assert property (p_ptr)
      else $error("pointer spare bits set");
   property p_trc; rd && paddr[13:2] == DSLAB_IDX_TRACE
      |=> prdata[7:2] == 6'h0; endproperty
   a_trc: assert property (p_trc)
      else $error("trace spare bits set");
   property p_tc; rd && paddr[13:2] == DSLAB_IDX_TANDEM
      |=> !prdata[0]; endproperty
   a_tc: assert property (p_tc)
      else $error("tandem spare bit set");
endmodule // dslab_bank_monitor
bind dslab_bank dslab_bank_monitor u_mon (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr);
`default_nettype wire

// file: verification/test_drop_side_latched_alarm_bank.sv
// self-checking bench for the drop-side latched alarm bank
`timescale 1ns/100ps
`default_nettype none
module test_drop_side_latched_alarm_bank;
   import dslab_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [DSLAB_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [DSLAB_NSRC-1:0] alarm_src = '0;
   logic n2_frame_valid = 1'b0;
   logic [7:0] n2_byte = 8'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, err;
   int n_fail = 0;
   int n_compared = 0;
   int bp [DSLAB_NSRC] = '{DSLAB_BIT_FIFO, DSLAB_BIT_AIS, DSLAB_BIT_LOP,
      DSLAB_BIT_NDF, DSLAB_BIT_SIZE, DSLAB_BIT_J2TIM, DSLAB_BIT_J2LOL,
      DSLAB_BIT_TCLM, DSLAB_BIT_TCLL, DSLAB_BIT_TCTM, DSLAB_BIT_TCAIS,
      DSLAB_BIT_TCUQ, DSLAB_BIT_TCRDI, DSLAB_BIT_TCODI};
   always #2.5 pclk = ~pclk;
   dslab_bank u_dslab_bank (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .alarm_src,
      .n2_frame_valid, .n2_byte, .irq);
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] idx,
         input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_fail++;
         print_verdict();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(exp, rd);
      check(32'h0, {31'h0, err});
   endtask
   task automatic frames(input int n);
      repeat (n) begin
         @(posedge pclk);
         n2_frame_valid <= 1'b1;
         @(posedge pclk);
         n2_frame_valid <= 1'b0;
      end
      repeat (6) @(posedge pclk);
   endtask
   function automatic logic [11:0] ridx(input int s);
      return s < 5 ? DSLAB_IDX_PTR_FIFO : s < 7 ? DSLAB_IDX_TRACE :
         DSLAB_IDX_TANDEM;
   endfunction
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(DSLAB_IDX_TANDEM, 32'h0);
      rd_chk(DSLAB_IDX_POLARITY, 32'h2);
      $display("test reset done");
      for (int s = 0; s < DSLAB_NSRC; s++) begin
         if (s == DSLAB_SRC_TCAIS) continue;
         for (int v = 1; v >= 0; v--) begin
            alarm_src[s] <= v[0];
            repeat (6) @(posedge pclk);
            rd_chk(ridx(s), 32'h1 << bp[s]);
            rd_chk(ridx(s), 32'h0);
         end
      end
      $display("test source map done");
      n2_byte <= 8'h10;
      frames(4);
      rd_chk(DSLAB_IDX_TANDEM, 32'h0);
      frames(1);
      rd_chk(DSLAB_IDX_TANDEM, 32'h10);
      n2_byte <= 8'h00;
      frames(5);
      rd_chk(DSLAB_IDX_TANDEM, 32'h10);
      // frame-seen flag is set by the frames above and cleared by a read
      rd_chk(DSLAB_IDX_TC_FRAME, 32'h1);
      rd_chk(DSLAB_IDX_TC_FRAME, 32'h0);
      $display("test tandem ais done");
      for (int p = 0; p < 3; p++) begin
         apb(1'b1, DSLAB_IDX_POLARITY, 32'(p));
         alarm_src[0] <= 1'b1;
         repeat (6) @(posedge pclk);
         rd_chk(DSLAB_IDX_PTR_FIFO, (p != 1) ? 32'h10 : 32'h0);
         alarm_src[0] <= 1'b0;
         repeat (6) @(posedge pclk);
         rd_chk(DSLAB_IDX_PTR_FIFO, (p != 0) ? 32'h10 : 32'h0);
      end
      apb(1'b1, DSLAB_IDX_POLARITY, 32'h3);
      rd_chk(DSLAB_IDX_POLARITY, 32'h2);
      apb(1'b1, DSLAB_IDX_PTR_FIFO, 32'hFF);
      rd_chk(DSLAB_IDX_PTR_FIFO, 32'h0);
      apb(1'b0, 12'h130, 32'h0);
      check(32'h1, {31'h0, err});
      // event lands in the latch at the very edge of the clearing read
      alarm_src[DSLAB_SRC_NDF] <= 1'b1;
      @(posedge pclk);
      rd_chk(DSLAB_IDX_PTR_FIFO, 32'h0);
      rd_chk(DSLAB_IDX_PTR_FIFO, 32'h1 << DSLAB_BIT_NDF);
      $display("test polarity and access done");
      apb(1'b1, DSLAB_IDX_IRQ_CLR, 32'h7);
      apb(1'b1, DSLAB_IDX_IRQ_EN, 32'h1);
      alarm_src[2] <= 1'b1;
      repeat (6) @(posedge pclk);
      check(32'h1, {31'h0, irq});
      rd_chk(DSLAB_IDX_IRQ_STAT, 32'h1);
      apb(1'b1, DSLAB_IDX_IRQ_CLR, 32'h1);
      repeat (2) @(posedge pclk);
      check(32'h0, {31'h0, irq});
      apb(1'b1, DSLAB_IDX_IRQ_EN, 32'h0);
      alarm_src[2] <= 1'b0;
      repeat (6) @(posedge pclk);
      check(32'h0, {31'h0, irq});
      rd_chk(DSLAB_IDX_IRQ_STAT, 32'h1);
      $display("test interrupt done");
      // reset in mid-run restores polarity and empties latches and status
      apb(1'b1, DSLAB_IDX_POLARITY, 32'h0);
      alarm_src <= '0;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(DSLAB_IDX_POLARITY, 32'h2);
      rd_chk(DSLAB_IDX_PTR_FIFO, 32'h0);
      rd_chk(DSLAB_IDX_IRQ_STAT, 32'h0);
      check(32'h0, {31'h0, irq});
      $display("test reset again done");
      print_verdict();
   end
endmodule // test_drop_side_latched_alarm_bank
`default_nettype wire
